/* File: hdl/spreader_pkg.sv */
// Constants, types and header-field helpers shared by the spreader block.
// Assumes one 10 MHz clock and a synchronous active-high reset everywhere.
package spreader_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ     = 10000;
  localparam int CHIP_KHZ    = 3840;
  localparam int FRAME_US    = 10000;
  localparam int SUBFRAME_US = 2000;
  localparam int SLOT_CHIPS_DEF     = 5120;
  localparam int FRAME_CHIPS_DEF    = FRAME_US * CHIP_KHZ / 1000;
  localparam int SUBFRAME_CHIPS_DEF = SUBFRAME_US * CHIP_KHZ / 1000;
  localparam logic [13:0] CHIP_STEP = 14'(CHIP_KHZ);
  localparam logic [13:0] CHIP_MOD  = 14'(CLK_KHZ);

  // ****************************************************************
  // Memory layout and fields
  // ****************************************************************
  localparam int          PM_WORDS  = 8;
  localparam int          WORD_W    = 3;
  localparam logic [2:0]  PM_CTRL   = 3'h0;
  localparam logic [2:0]  PM_OFFSET = 3'h1;
  localparam logic [2:0]  PM_BUF    = 3'h2;
  localparam logic [2:0]  PM_HDR    = 3'h3;
  localparam int          TYPE_LSB  = 0;
  localparam int          TYPE_W    = 4;
  localparam int          STTD_BIT  = 4;
  localparam int          RM_ACT_BIT  = 0;
  localparam int          RM_DUAL_BIT = 1;
  localparam int          HDR_DTX_BIT = 10;
  localparam logic [31:0] M_RLS  = 32'h0000000f;
  localparam logic [31:0] M_CODE = 32'h000000f0;
  localparam logic [31:0] M_MOD  = 32'h00000300;
  localparam logic [31:0] M_DTX  = 32'h00000400;
  localparam logic [31:0] M_DIV  = 32'h00000800;
  localparam logic [31:0] M_SLOT = 32'h00001000;
  localparam logic [31:0] M_CM   = 32'h0000e000;
  localparam logic [31:0] M_GAIN = 32'h00ff0000;
  localparam logic [31:0] M_NEXT = 32'hff000000;
  localparam logic [31:0] PAY_STEP = 32'h00000004;

  // ****************************************************************
  // Bus map
  // ****************************************************************
  localparam int         PM_IDX_LSB   = 5;
  localparam int         WORD_LSB     = 2;
  localparam int         RM_IDX_LSB   = 2;
  localparam logic [1:0] ADR_PM_SEL   = 2'h0;
  localparam logic [2:0] ADR_RM_SEL   = 3'h4;
  localparam logic [9:0] ADR_ACTIVE   = 10'h180;
  localparam logic [9:0] ADR_PENDING  = 10'h184;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    CH_PSCH, CH_SSCH, CH_PCPICH, CH_SCPICH, CH_AICH, CH_EAICH,
    CH_PCCPCH, CH_SCCPCH, CH_PICH, CH_MICH, CH_DPCH, CH_FDPCH,
    CH_HSSCCH, CH_HSPDSCH, CH_EHICH, CH_EAGCH
  } chan_type_t;
  typedef enum logic [1:0] {PER_NONE, PER_SLOT, PER_FRAME, PER_SUB} period_t;
  typedef enum logic [1:0] {F_IDLE, F_HDR, F_WR, F_PAY} fetch_state_t;

  function automatic period_t period_of(input chan_type_t t);
    case (t)
      CH_PSCH, CH_SSCH, CH_PCPICH, CH_SCPICH: period_of = PER_NONE;
      CH_AICH, CH_EAICH:                      period_of = PER_SLOT;
      CH_HSSCCH, CH_HSPDSCH, CH_EHICH, CH_EAGCH: period_of = PER_SUB;
      default:                                period_of = PER_FRAME;
    endcase
  endfunction

  // Which header bits the fetch may overwrite, per channel type
  function automatic logic [31:0] hdr_mask(input chan_type_t t);
    case (t)
      CH_DPCH:    hdr_mask = M_SLOT | M_DTX | M_CM | M_NEXT;
      CH_MICH, CH_PICH, CH_PCCPCH: hdr_mask = M_GAIN | M_DTX;
      CH_SCCPCH:  hdr_mask = M_GAIN | M_DTX | M_NEXT;
      CH_FDPCH:   hdr_mask = M_SLOT | M_DTX;
      CH_HSPDSCH: hdr_mask = M_RLS | M_CODE | M_MOD | M_DTX | M_DIV | M_NEXT;
      CH_HSSCCH:  hdr_mask = M_DIV | M_DTX;
      default:    hdr_mask = M_DTX;
    endcase
  endfunction

endpackage

/* File: hdl/pm_if.sv */
// Carrier between the top level and the parameter memory.
// Assumes N and IW agree with the parameter memory instance.
`timescale 1ns/10ps
interface pm_if #(parameter int N = 8, parameter int IW = 3);
  logic        sw_we;
  logic [IW-1:0] sw_idx;
  logic [2:0]  sw_word;
  logic [3:0]  sw_sel;
  logic [31:0] sw_dat;
  logic [31:0] rd_dat;
  logic        f_we;
  logic [IW-1:0] f_idx;
  logic [31:0] f_dat;
  logic [31:0] ctrl [N];
  logic [31:0] offs [N];
  logic [31:0] bptr [N];
  logic [31:0] hdr  [N];
  modport mem  (input sw_we, sw_idx, sw_word, sw_sel, sw_dat, f_we, f_idx, f_dat,
                output rd_dat, ctrl, offs, bptr, hdr);
  modport user (output sw_we, sw_idx, sw_word, sw_sel, sw_dat, f_we, f_idx, f_dat,
                input rd_dat, ctrl, offs, bptr, hdr);
endinterface

/* File: hdl/spreader_param_mem.sv */
// Per-spreader parameter memory with a software port and a fetch port.
// Assumes software writes are spaced at least two cycles apart.
`timescale 1ns/10ps
module spreader_param_mem #(
  parameter int NUM_SPR = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  pm_if.mem        pm
);
  localparam int IW = $clog2(NUM_SPR);
  localparam int AW = IW + spreader_pkg::WORD_W;

  logic [31:0]   mem_q [NUM_SPR*spreader_pkg::PM_WORDS];
  logic          hold_q;
  logic [AW-1:0] hold_a_q;
  logic [3:0]    hold_sel_q;
  logic [31:0]   hold_dat_q;
  logic [AW-1:0] sw_a;
  logic [AW-1:0] f_a;
  logic [AW-1:0] f_ca;
  logic [31:0]   f_m;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction

  assign sw_a      = {pm.sw_idx, pm.sw_word};
  assign f_a       = {pm.f_idx, spreader_pkg::PM_HDR};
  assign f_ca      = {pm.f_idx, spreader_pkg::PM_CTRL};
  assign f_m       = spreader_pkg::hdr_mask(spreader_pkg::chan_type_t'(
                       mem_q[f_ca][spreader_pkg::TYPE_LSB +: spreader_pkg::TYPE_W]));
  assign pm.rd_dat = mem_q[sw_a];

  for (genvar i = 0; i < NUM_SPR; i++) begin : g_out
    assign pm.ctrl[i] = mem_q[{IW'(i), spreader_pkg::PM_CTRL}];
    assign pm.offs[i] = mem_q[{IW'(i), spreader_pkg::PM_OFFSET}];
    assign pm.bptr[i] = mem_q[{IW'(i), spreader_pkg::PM_BUF}];
    assign pm.hdr[i]  = mem_q[{IW'(i), spreader_pkg::PM_HDR}];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
      for (int k = 0; k < NUM_SPR*spreader_pkg::PM_WORDS; k++) mem_q[k] <= 32'h0;
    end else begin
      // Fetch always commits; software waits a cycle in the hold slot
      if (pm.f_we) begin
        mem_q[f_a] <= (mem_q[f_a] & ~f_m) | (pm.f_dat & f_m);
      end else if (hold_q) begin
        mem_q[hold_a_q] <= merge(mem_q[hold_a_q], hold_dat_q, hold_sel_q);
      end else if (pm.sw_we) begin
        mem_q[sw_a] <= merge(mem_q[sw_a], pm.sw_dat, pm.sw_sel);
      end
      hold_q <= pm.sw_we & (pm.f_we | hold_q);
      if (pm.sw_we) begin
        hold_a_q   <= sw_a;
        hold_sel_q <= pm.sw_sel;
        hold_dat_q <= pm.sw_dat;
      end
    end
  end
endmodule // spreader_param_mem

/* File: hdl/spreader_lane.sv */
// One spreader: period timing, payload shifter, scrambler and STTD encoder.
// Assumes chip_tick_i is a one-cycle pulse at chip rate.
`timescale 1ns/10ps
module spreader_lane #(
  parameter logic [15:0] SLOT_CHIPS     = 16'(spreader_pkg::SLOT_CHIPS_DEF),
  parameter logic [15:0] SUBFRAME_CHIPS = 16'(spreader_pkg::SUBFRAME_CHIPS_DEF),
  parameter logic [15:0] FRAME_CHIPS    = 16'(spreader_pkg::FRAME_CHIPS_DEF),
  parameter logic [17:0] SEED           = 18'h00001
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        chip_tick_i,
  input  wire logic        act_req_i,
  input  wire logic        dual_req_i,
  input  wire logic [31:0] ctrl_i,
  input  wire logic [15:0] offset_i,
  input  wire logic [31:0] hdr_i,
  input  wire logic        load_i,
  input  wire logic [31:0] payload_i,
  output logic             active_o,
  output logic             fetch_due_o,
  output logic             prim_o,
  output logic             div_o
);
  spreader_pkg::chan_type_t ctype;
  spreader_pkg::period_t    per;
  logic [15:0] plen;
  logic        fetching;
  logic        start;
  logic        wrap;
  logic        run;
  logic        dtx;
  logic        div_en;
  logic        prim_d;
  logic        div_d;
  logic        active_q;
  logic        due_q;
  logic        phase_q;
  logic        hold_q;
  logic        prim_q;
  logic        div_q;
  logic [15:0] cnt_q;
  logic [31:0] sr_q;
  logic [17:0] lfsr_q;

  assign ctype    = spreader_pkg::chan_type_t'(ctrl_i[spreader_pkg::TYPE_LSB +:
                                                      spreader_pkg::TYPE_W]);
  assign per      = spreader_pkg::period_of(ctype);
  assign plen     = per == spreader_pkg::PER_SLOT ? SLOT_CHIPS :
                    per == spreader_pkg::PER_SUB  ? SUBFRAME_CHIPS : FRAME_CHIPS;
  assign fetching = per != spreader_pkg::PER_NONE;
  assign run      = chip_tick_i & active_q;
  assign start    = chip_tick_i & act_req_i & ~active_q;
  // Own counter per lane, so no neighbour's timing leaks in
  assign wrap     = run & (cnt_q == plen - 16'h0001);
  assign dtx      = hdr_i[spreader_pkg::HDR_DTX_BIT];
  assign div_en   = dual_req_i & ctrl_i[spreader_pkg::STTD_BIT];
  assign prim_d   = sr_q[0] ^ lfsr_q[0];
  // STTD pairs: even chip sends -b, odd chip sends held a, then scramble
  assign div_d    = (phase_q ? hold_q : ~sr_q[1]) ^ lfsr_q[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
      due_q    <= 1'b0;
      phase_q  <= 1'b0;
      hold_q   <= 1'b0;
      prim_q   <= 1'b0;
      div_q    <= 1'b0;
      cnt_q    <= 16'h0;
      sr_q     <= 32'h0;
      lfsr_q   <= SEED;
    end else begin
      due_q <= (start | (wrap & act_req_i)) & fetching;
      if (chip_tick_i) active_q <= act_req_i;
      if (start) cnt_q <= offset_i < plen ? offset_i : 16'h0;
      else if (wrap) cnt_q <= 16'h0;
      else if (run) cnt_q <= cnt_q + 16'h0001;
      if (load_i) sr_q <= payload_i;
      else if (run) sr_q <= {1'b0, sr_q[31:1]};
      if (start | wrap) begin
        lfsr_q  <= SEED;
        phase_q <= 1'b0;
      end else if (run) begin
        lfsr_q  <= {lfsr_q[0] ^ lfsr_q[7], lfsr_q[17:1]};
        phase_q <= ~phase_q;
        if (!phase_q) hold_q <= sr_q[0];
      end
      if (!active_q) begin
        prim_q <= 1'b0;
        div_q  <= 1'b0;
      end else if (run) begin
        prim_q <= ~dtx & prim_d;
        div_q  <= ~dtx & div_en & div_d;
      end
    end
  end

  assign active_o    = active_q;
  assign fetch_due_o = due_q;
  assign prim_o      = prim_q;
  assign div_o       = div_q;
endmodule // spreader_lane

/* File: hdl/wcdma_spreader_control.sv */
// Top of the downlink spreader set: Wishbone registers, chip timing,
// header/payload fetch engine and the spreader lanes.
// Assumes a memory port that holds data ready and answers with mem_ack_i.
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/10ps
module wcdma_spreader_control #(
  parameter int unsigned NUM_SPR        = 8,
  parameter int unsigned SLOT_CHIPS     = spreader_pkg::SLOT_CHIPS_DEF,
  parameter int unsigned SUBFRAME_CHIPS = spreader_pkg::SUBFRAME_CHIPS_DEF,
  parameter int unsigned FRAME_CHIPS    = spreader_pkg::FRAME_CHIPS_DEF
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [9:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    mem_req_o,
  output logic      [31:0]        mem_adr_o,
  input  wire logic               mem_ack_i,
  input  wire logic [31:0]        mem_dat_i,
  output logic      [NUM_SPR-1:0] prim_o,
  output logic      [NUM_SPR-1:0] div_o,
  output logic      [NUM_SPR-1:0] active_o
);
  localparam int IW = $clog2(NUM_SPR);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NUM_SPR < 2 || NUM_SPR > 8 || (NUM_SPR & (NUM_SPR - 1)) != 0) begin : g_bad_n
    $error("NUM_SPR must be 2, 4 or 8");
  end
  if (SLOT_CHIPS < 2 || SUBFRAME_CHIPS < 2 || FRAME_CHIPS < 2 ||
      SLOT_CHIPS > 65535 || SUBFRAME_CHIPS > 65535 || FRAME_CHIPS > 65535) begin : g_bad_t
    $error("Period lengths must lie in 2..65535 chips");
  end

  // ****************************************************************
  // Chip-rate enable
  // ****************************************************************
  // Fractional accumulator keeps the average chip rate exact
  logic [13:0] acc_q;
  logic [13:0] acc_sum;
  logic        chip_tick;
  logic        tick_q;

  assign acc_sum   = acc_q + spreader_pkg::CHIP_STEP;
  assign chip_tick = tick_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q  <= 14'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= acc_sum >= spreader_pkg::CHIP_MOD;
      acc_q  <= acc_sum >= spreader_pkg::CHIP_MOD ? acc_sum - spreader_pkg::CHIP_MOD : acc_sum;
    end
  end

  // ****************************************************************
  // Wishbone slave decode
  // ****************************************************************
  pm_if #(.N(NUM_SPR), .IW(IW)) pm ();

  logic          req;
  logic          wr;
  logic          is_pm;
  logic          is_rm;
  logic          is_act;
  logic          is_pend;
  logic [IW-1:0] rm_idx;
  logic [31:0]   rd_dat;
  logic          ack_q;
  logic [31:0]   dat_q;
  logic [1:0]    rm_q [NUM_SPR];
  logic [NUM_SPR-1:0] act_w;
  logic [NUM_SPR-1:0] due_w;
  logic [NUM_SPR-1:0] pend_q;

  assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr      = req & wb_we_i;
  assign is_pm   = wb_adr_i[9:8] == spreader_pkg::ADR_PM_SEL &&
                   {1'b0, wb_adr_i[7:5]} < 4'(NUM_SPR);
  assign is_rm   = wb_adr_i[9:7] == spreader_pkg::ADR_RM_SEL &&
                   wb_adr_i[6:2] < 5'(NUM_SPR) && wb_adr_i[1:0] == 2'h0;
  assign is_act  = wb_adr_i == spreader_pkg::ADR_ACTIVE;
  assign is_pend = wb_adr_i == spreader_pkg::ADR_PENDING;
  assign rm_idx  = wb_adr_i[spreader_pkg::RM_IDX_LSB +: IW];
  assign rd_dat  = is_pm   ? pm.rd_dat :
                   is_rm   ? {30'h0, rm_q[rm_idx]} :
                   is_act  ? 32'(act_w) :
                   is_pend ? 32'(pend_q) : 32'h0;

  assign pm.sw_we   = wr & is_pm;
  assign pm.sw_idx  = wb_adr_i[spreader_pkg::PM_IDX_LSB +: IW];
  assign pm.sw_word = wb_adr_i[spreader_pkg::WORD_LSB +: spreader_pkg::WORD_W];
  assign pm.sw_sel  = wb_sel_i;
  assign pm.sw_dat  = wb_dat_i;

  // Answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req;
      if (req) dat_q <= wb_we_i ? 32'h0 : rd_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SPR; i++) rm_q[i] <= 2'h0;
    end else if (wr && is_rm && wb_sel_i[0]) begin
      rm_q[rm_idx] <= wb_dat_i[1:0];
    end
  end

  spreader_param_mem #(
    .NUM_SPR (NUM_SPR)
  ) u_pm (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pm    (pm.mem)
  );

  // ****************************************************************
  // Fetch engine: header word, then payload word
  // ****************************************************************
  spreader_pkg::fetch_state_t fst_q;
  logic [IW-1:0]      pick;
  logic [IW-1:0]      fidx_q;
  logic               fstart;
  logic [NUM_SPR-1:0] clr;
  logic [31:0]        hdr_q;
  logic               pay_ld;
  logic               req_q;
  logic [31:0]        adr_q;

  always_comb begin
    pick = '0;
    for (int i = NUM_SPR - 1; i >= 0; i--) begin
      if (pend_q[i]) pick = IW'(i);
    end
  end

  assign fstart   = fst_q == spreader_pkg::F_IDLE && |pend_q;
  assign clr      = fstart ? NUM_SPR'(1) << pick : '0;
  assign pay_ld   = fst_q == spreader_pkg::F_PAY && mem_ack_i;
  assign pm.f_we  = fst_q == spreader_pkg::F_WR;
  assign pm.f_idx = fidx_q;
  assign pm.f_dat = hdr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else begin
      // A new period due in the same cycle as the clear is kept
      pend_q <= (pend_q & ~clr) | due_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fst_q  <= spreader_pkg::F_IDLE;
      fidx_q <= '0;
      hdr_q  <= 32'h0;
      req_q  <= 1'b0;
      adr_q  <= 32'h0;
    end else begin
      case (fst_q)
        spreader_pkg::F_IDLE: begin
          if (fstart) begin
            fidx_q <= pick;
            adr_q  <= pm.bptr[pick];
            req_q  <= 1'b1;
            fst_q  <= spreader_pkg::F_HDR;
          end
        end
        spreader_pkg::F_HDR: begin
          if (mem_ack_i) begin
            hdr_q <= mem_dat_i;
            req_q <= 1'b0;
            fst_q <= spreader_pkg::F_WR;
          end
        end
        spreader_pkg::F_WR: begin
          adr_q <= adr_q + spreader_pkg::PAY_STEP;
          req_q <= 1'b1;
          fst_q <= spreader_pkg::F_PAY;
        end
        spreader_pkg::F_PAY: begin
          if (mem_ack_i) begin
            req_q <= 1'b0;
            fst_q <= spreader_pkg::F_IDLE;
          end
        end
        default: begin
          req_q <= 1'b0;
          fst_q <= spreader_pkg::F_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Spreader lanes
  // ****************************************************************
  for (genvar i = 0; i < NUM_SPR; i++) begin : g_lane
    spreader_lane #(
      .SLOT_CHIPS     (16'(SLOT_CHIPS)),
      .SUBFRAME_CHIPS (16'(SUBFRAME_CHIPS)),
      .FRAME_CHIPS    (16'(FRAME_CHIPS)),
      .SEED           (18'h00001 + 18'(i))
    ) u_lane (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .chip_tick_i (chip_tick),
      .act_req_i   (rm_q[i][spreader_pkg::RM_ACT_BIT]),
      .dual_req_i  (rm_q[i][spreader_pkg::RM_DUAL_BIT]),
      .ctrl_i      (pm.ctrl[i]),
      .offset_i    (pm.offs[i][15:0]),
      .hdr_i       (pm.hdr[i]),
      .load_i      (pay_ld && fidx_q == IW'(i)),
      .payload_i   (mem_dat_i),
      .active_o    (act_w[i]),
      .fetch_due_o (due_w[i]),
      .prim_o      (prim_o[i]),
      .div_o       (div_o[i])
    );
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;
  assign mem_req_o = req_q;
  assign mem_adr_o = adr_q;
  assign active_o  = act_w;
endmodule // wcdma_spreader_control

/* File: bench/fetch_mem_model.sv */
// Fetch memory model: header at even words, payload at odd words.
// Assumes the device holds req and address until the ack edge.
`timescale 1ns/10ps
module fetch_mem_model #(
  parameter logic [31:0] HDR = 32'h00000000,
  parameter logic [31:0] PAY = 32'hc3a50f96
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [1:0]  dly_i,
  output logic             ack_o,
  output logic      [31:0] dat_o
);
  // ****
  // Answer
  // ****
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || ack_o) begin
      ack_o <= 1'b0;
      cnt_q <= 2'h0;
      dat_o <= rst_i ? 32'h5a5a5a5a : ~dat_o; // Stale data must not look valid
    end else if (cnt_q == dly_i) begin
      ack_o <= 1'b1;
      dat_o <= adr_i[2] ? PAY : HDR;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      dat_o <= ~dat_o;
    end
  end
endmodule // fetch_mem_model

/* File: bench/wcdma_spreader_control_asserts.sv */
// Checker of bus answers and fetch port timing at the spreader top.
// Assumes it is bound to every wcdma_spreader_control instance.
`timescale 1ns/10ps
module wcdma_spreader_control_asserts #(
  parameter int unsigned NUM_SPR = 8
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [9:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               mem_req_o,
  input wire logic [31:0]        mem_adr_o,
  input wire logic               mem_ack_i,
  input wire logic [31:0]        mem_dat_i,
  input wire logic [NUM_SPR-1:0] prim_o,
  input wire logic [NUM_SPR-1:0] div_o,
  input wire logic [NUM_SPR-1:0] active_o
);
  // ****
  // Checks
  // ****
  logic pay_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pay_q <= 1'b0;
    end else if (mem_req_o && mem_ack_i) begin
      pay_q <= ~pay_q; // Header and payload words alternate
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hdr_ack;
    mem_req_o && mem_ack_i && !pay_q;
  endsequence
  sequence s_pay_req;
    !mem_req_o ##1 (mem_req_o && mem_adr_o == $past(mem_adr_o, 2) + 32'h4);
  endsequence
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_bound: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o)
    else $error("bus request not answered in time");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_adr_o))
    else $error("fetch request changed before ack");
  chk_req_drop: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("fetch request held after ack");
  chk_pay_next: assert property (s_hdr_ack |=> s_pay_req)
    else $error("payload read does not follow header");
  chk_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !wb_ack_o && !mem_req_o && active_o == '0)
    else $error("outputs busy after reset");
  chk_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) >= 10'h188
    && !($past(wb_adr_i) >= 10'h200 && $past(wb_adr_i) < 10'h220)
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // wcdma_spreader_control_asserts
bind wcdma_spreader_control wcdma_spreader_control_asserts #(.NUM_SPR(NUM_SPR)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_adr_o, .mem_ack_i, .mem_dat_i, .prim_o,
  .div_o, .active_o);

/* File: bench/wcdma_spreader_control_bench.sv */
// Bench: Wishbone tasks and a sweep of all channel types on spreader 0.
// Assumes short period parameters (8/12/16 chips) to keep the run brief.
`timescale 1ns/10ps
module wcdma_spreader_control_bench;
  localparam logic [31:0] HDRV = 32'h5a3c0a65;
  localparam logic [31:0] MASK [16] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h400, 32'h400,
    32'hff0400, 32'hffff0400, 32'hff0400, 32'hff0400, 32'hff00f400, 32'h1400, 32'hc00,
    32'hff000fff, 32'h400, 32'h400};
  localparam logic [9:0] RADR [5] = '{10'h000, 10'h00c, 10'h21c, 10'h180, 10'h1fc};
  logic        clk_i = 1'b0;
  logic        rst_i, cyc, stb, we, ack, mreq, mack;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [1:0]  dly;
  logic [31:0] wdat, rdat, madr, mdat;
  logic [7:0]  prim, div, act;
  int          err_total, num_checks;
  always #50 clk_i = ~clk_i;
  wcdma_spreader_control #(.NUM_SPR(8), .SLOT_CHIPS(8), .SUBFRAME_CHIPS(12),
    .FRAME_CHIPS(16)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mem_req_o(mreq), .mem_adr_o(madr), .mem_ack_i(mack), .mem_dat_i(mdat),
    .prim_o(prim), .div_o(div), .active_o(act));
  fetch_mem_model #(.HDR(HDRV)) mem (.clk_i, .rst_i, .req_i(mreq), .adr_i(madr),
    .dly_i(dly), .ack_o(mack), .dat_o(mdat));
  // ****
  // Tasks
  // ****
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("bus ack", 32'h1, 32'h0);
      end_of_test();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask
  // ****
  // Sequence
  // ****
  initial begin : main
    logic [31:0] m;
    logic        dual, dseen, pseen;
    int          k, per;
    time         t1, t2;
    {cyc, stb, we, adr, sel, wdat, dly} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(10'h180, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      rd("reset value", RADR[i], 32'h0);
    end
    wr(10'h008, 32'h00000040);
    for (int t = 0; t < 16; t++) begin
      m = MASK[t];
      dual = t[0] && m != 0;
      dly <= t[1:0];
      wr(10'h000, 32'h00000010 | 32'(t));
      wr(10'h00c, 32'hffffffff);
      // Only spreader 0 runs, so no neighbour ever differs in timing
      wr(10'h200, {30'h0, dual, 1'b1});
      k = 0;
      dseen = 1'b0;
      pseen = 1'b0;
      for (int n = 0; n < 200 && k < 2; n++) begin
        @(posedge clk_i);
        dseen = dseen | div[0];
        pseen = pseen | prim[0];
        if (mack === 1'b1 && madr[2] === 1'b0) begin
          k++;
          if (k == 1) begin
            t1 = $time;
            wr(10'h070, 32'h6b6b0000 | 32'(t)); // Lands on the header write cycle
            // Checked before the next fetch could rewrite the same fields
            rd("collision header", 10'h00c, ~m | (HDRV & m));
          end else begin
            t2 = $time;
          end
        end
      end
      chk("fetch count", (m != 0) ? 32'h2 : 32'h0, 32'(k));
      if (k == 2) begin
        per = (t < 6) ? 21 : (t > 11) ? 31 : 42;
        chk("period", 32'h1, 32'((t2 - t1) / 100 >= per - 2 && (t2 - t1) / 100 <= per + 2));
        rd("collided write", 10'h070, 32'h6b6b0000 | 32'(t));
      end
      rd("header fields", 10'h00c, ~m | (HDRV & m));
      chk("diversity", {31'h0, dual}, {31'h0, dseen});
      chk("primary", {31'h0, m != 0}, {31'h0, pseen});
      rd("active mask", 10'h180, 32'h1);
      wr(10'h200, 32'h0);
      for (int n = 0; n < 50 && (act[0] !== 1'b0 || mreq !== 1'b0); n++) begin
        @(posedge clk_i);
      end
      chk("lane idle", 32'h0, {31'h0, act[0] | mreq});
    end
    end_of_test();
  end
endmodule // wcdma_spreader_control_bench
